// [rtl/rnh_ctrl.sv]
/*
 * host-side controller for a raw quantum noise chip on spi.
 * checks the tamper link, initialises the chip, polls ready status,
 * reads 16-byte frames, validates them, runs the run-length and
 * window-proportion checks, discards start-up data and buffers the rest.
 * assumes the chip is strapped for spi, mode 0, msb first.
 */
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// R1 - device packs two-bit samples into bytes
// R2 - device outputs full-range 8-bit bytes
// R3 - fifo fill and spi drain run independently
// R4 - read only after status shows ready
// R5 - each fetch collects exactly sixteen bytes
// R6 - only valid-format frames reach health checks
// R7 - retry failed reads, then critical error
// R8 - device picks spi or i2c by strap
// R9 - sample mode bypasses internal conditioning
// R10 - send init sequence before expecting data
// R11 - device self-calibrates emitter and exposure
// R12 - calibration failure puts device in failure
// R13 - check then discard about 4000 start bytes
// R14 - run check fails at 21 repeats
// R15 - window of 512 fails at 248 hits
// R16 - health failure: error, halt, request reboot
// R17 - device swaps to standby emitter
// R18 - discard samples of restart health tests
// R19 - tamper link failure gives tamper error
// R20 - run count restarts at one on change
// R21 - window reference is its first sample
module rnh_ctrl import rnh_pkg::*; #(
  parameter int SPI_DIV = SPI_DIV_CYC,
  parameter int DISCARD = DISCARD_FRAMES,
  parameter int RETRIES = MAX_RETRY
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic restart,
  input wire logic tamper_ok,
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_mosi,
  input wire logic spi_miso,
  output logic [7:0] noise_data,
  output logic noise_valid,
  input wire logic noise_ready,
  output logic svc_ready,
  output logic [2:0] err_code,
  output logic reboot_req
);
  localparam int DW = $clog2(DISCARD + 1);
  localparam int RW = $clog2(RETRIES + 1);
  localparam int TW = $clog2(TAMPER_WAIT_CYC);
  localparam int WW = $clog2(WIN_LEN);
  localparam int DVW = $clog2(SPI_DIV);

  // ==========================================================
  // parameter checks
  if (SPI_DIV < 2 || DISCARD < 1 || RETRIES < 1) begin : g_bad_param
    $error("rnh_ctrl: divider >= 2, discard >= 1, retries >= 1 required");
  end

  typedef enum logic [3:0] {
    ST_TAMPER = 4'h0,
    ST_INIT = 4'h1,
    ST_POLL_CMD = 4'h2,
    ST_POLL_RSP = 4'h3,
    ST_READ_CMD = 4'h4,
    ST_READ_HDR = 4'h5,
    ST_READ_DATA = 4'h6,
    ST_GAP = 4'h7,
    ST_ERROR = 4'h8
  } rnh_state_t;

  rnh_state_t st_reg;
  rnh_state_t nxt_reg;
  logic [4:0] idx_reg;
  logic [TW-1:0] wait_reg;
  logic [RW-1:0] retry_reg;
  logic [DW-1:0] discard_reg;
  rnh_err_t err_reg;
  logic reboot_reg;
  logic cs_n_reg;
  logic [DVW-1:0] div_reg;
  logic tick;
  logic busy_reg;
  logic done_reg;
  logic phase_reg;
  logic sclk_reg;
  logic [2:0] bit_reg;
  logic [7:0] tx_sh_reg;
  logic [7:0] rx_sh_reg;
  logic [7:0] tx_byte;
  logic want;
  logic start;
  logic hv;
  logic hfail;
  logic run_hit;
  logic push;
  logic fifo_in_ready;
  logic [7:0] prev_reg;
  logic have_prev_reg;
  logic [4:0] run_reg;
  logic [4:0] run_next;
  logic [WW-1:0] widx_reg;
  logic [7:0] wref_reg;
  logic [8:0] wcnt_reg;
  logic [8:0] wcnt_next;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  // ==========================================================
  // spi bit-rate divider: one-cycle tick per half sclk period
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      div_reg <= '0;
    end else if (div_reg == DVW'(SPI_DIV - 1)) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 1'b1;
    end
  end
  assign tick = div_reg == DVW'(SPI_DIV - 1);

  // ==========================================================
  // byte engine, mode 0: sample on rise, shift on fall
  always_comb begin
    unique case (st_reg)
      ST_INIT: tx_byte = INIT_SEQ[idx_reg[1:0]];
      ST_POLL_CMD: tx_byte = CMD_STATUS;
      ST_READ_CMD: tx_byte = CMD_READ;
      default: tx_byte = CMD_DUMMY;
    endcase
  end

  // host owns sclk, so a full fifo simply pauses between bytes
  assign want = !cs_n_reg && (st_reg inside {ST_INIT, ST_POLL_CMD,
    ST_POLL_RSP, ST_READ_CMD, ST_READ_HDR, ST_READ_DATA}) &&
    (st_reg != ST_READ_DATA || discard_reg != '0 || fifo_in_ready); // [R3]
  assign start = want && !busy_reg && !done_reg && !restart;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      phase_reg <= 1'b0;
      sclk_reg <= 1'b0;
      bit_reg <= '0;
      tx_sh_reg <= '0;
      rx_sh_reg <= '0;
    end else begin
      done_reg <= 1'b0;
      if (restart) begin
        busy_reg <= 1'b0;
        sclk_reg <= 1'b0;
        phase_reg <= 1'b0;
      end else if (start) begin
        busy_reg <= 1'b1;
        phase_reg <= 1'b0;
        bit_reg <= '0;
        tx_sh_reg <= tx_byte;
      end else if (busy_reg && tick) begin
        if (!phase_reg) begin
          sclk_reg <= 1'b1;
          rx_sh_reg <= {rx_sh_reg[6:0], spi_miso};
          phase_reg <= 1'b1;
        end else begin
          sclk_reg <= 1'b0;
          phase_reg <= 1'b0;
          if (bit_reg == 3'h7) begin
            busy_reg <= 1'b0;
            done_reg <= 1'b1;
          end else begin
            bit_reg <= bit_reg + 1'b1;
            tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
          end
        end
      end
    end
  end
  assign spi_sclk = sclk_reg;
  assign spi_mosi = tx_sh_reg[7];

  // ==========================================================
  // health checks on validated bytes only
  assign hv = done_reg && st_reg == ST_READ_DATA; // [R6]
  assign run_next = (have_prev_reg && rx_sh_reg == prev_reg) ?
    run_reg + 1'b1 : 5'h01; // [R20]
  assign wcnt_next = (widx_reg == '0) ? 9'h001 :
    (rx_sh_reg == wref_reg) ? wcnt_reg + 1'b1 : wcnt_reg; // [R21]
  assign run_hit = run_next == RUN_CUT; // [R14]
  assign hfail = hv && (run_hit || wcnt_next == WIN_CUT); // [R15]

  // counters start over after reset or an on-demand restart
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      prev_reg <= '0;
      have_prev_reg <= 1'b0;
      run_reg <= '0;
      widx_reg <= '0;
      wref_reg <= '0;
      wcnt_reg <= '0;
    end else if (restart) begin
      have_prev_reg <= 1'b0;
      run_reg <= '0;
      widx_reg <= '0;
      wcnt_reg <= '0;
    end else if (hv) begin
      prev_reg <= rx_sh_reg;
      have_prev_reg <= 1'b1;
      run_reg <= run_next;
      wcnt_reg <= wcnt_next;
      widx_reg <= widx_reg + 1'b1; // wraps at the window length
      if (widx_reg == '0) begin
        wref_reg <= rx_sh_reg;
      end
    end
  end

  // ==========================================================
  // sequencing: tamper, init, poll, read, validate, retry, error
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st_reg <= ST_TAMPER;
      nxt_reg <= ST_POLL_CMD;
      idx_reg <= '0;
      wait_reg <= '0;
      retry_reg <= '0;
      discard_reg <= DW'(DISCARD);
      err_reg <= ERR_NONE;
      reboot_reg <= 1'b0;
    end else begin
      reboot_reg <= 1'b0;
      if (restart) begin
        st_reg <= ST_TAMPER;
        idx_reg <= '0;
        wait_reg <= '0;
        retry_reg <= '0;
        discard_reg <= DW'(DISCARD); // [R18]
        err_reg <= ERR_NONE;
      end else if (hfail) begin
        st_reg <= ST_ERROR; // [R16]
        err_reg <= run_hit ? ERR_RUN : ERR_WINDOW;
        reboot_reg <= 1'b1;
      end else begin
        unique case (st_reg)
          ST_TAMPER: begin
            if (tamper_ok) begin
              st_reg <= ST_INIT;
              idx_reg <= '0;
            end else if (wait_reg == TW'(TAMPER_WAIT_CYC - 1)) begin
              st_reg <= ST_ERROR; // [R19]
              err_reg <= ERR_TAMPER;
              reboot_reg <= 1'b1;
            end else begin
              wait_reg <= wait_reg + 1'b1;
            end
          end
          ST_INIT: if (done_reg) begin
            if (idx_reg == 5'(INIT_LEN - 1)) begin
              idx_reg <= '0;
              st_reg <= ST_GAP; // [R10]
              nxt_reg <= ST_POLL_CMD;
            end else begin
              idx_reg <= idx_reg + 1'b1;
            end
          end
          ST_POLL_CMD: if (done_reg) st_reg <= ST_POLL_RSP;
          ST_POLL_RSP: if (done_reg) begin
            if (rx_sh_reg[STAT_FAIL_BIT]) begin
              st_reg <= ST_ERROR;
              err_reg <= ERR_DEVICE;
              reboot_reg <= 1'b1;
            end else if (rx_sh_reg[STAT_RDY_BIT]) begin
              st_reg <= ST_READ_CMD; // [R4]
            end else begin
              st_reg <= ST_GAP;
              nxt_reg <= ST_POLL_CMD;
            end
          end
          ST_READ_CMD: if (done_reg) st_reg <= ST_READ_HDR;
          ST_READ_HDR: if (done_reg) begin
            if (rx_sh_reg == FRAME_HDR) begin
              st_reg <= ST_READ_DATA; // [R6]
              idx_reg <= '0;
            end else if (retry_reg == RW'(RETRIES)) begin
              st_reg <= ST_ERROR; // [R7]
              err_reg <= ERR_READ;
              reboot_reg <= 1'b1;
            end else begin
              retry_reg <= retry_reg + 1'b1;
              st_reg <= ST_GAP;
              nxt_reg <= ST_POLL_CMD;
            end
          end
          ST_READ_DATA: if (done_reg) begin
            if (idx_reg == 5'(FRAME_BYTES - 1)) begin
              idx_reg <= '0; // [R5]
              retry_reg <= '0;
              st_reg <= ST_GAP;
              nxt_reg <= ST_POLL_CMD;
              if (discard_reg != '0) begin
                discard_reg <= discard_reg - 1'b1; // [R13]
              end
            end else begin
              idx_reg <= idx_reg + 1'b1;
            end
          end
          ST_GAP: if (tick) st_reg <= nxt_reg;
          ST_ERROR: ; // halted until restart or reboot
          default: st_reg <= ST_ERROR;
        endcase
      end
    end
  end

  // chip select deasserted outside transactions, settles before bytes
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cs_n_reg <= 1'b1;
    end else begin
      cs_n_reg <= st_reg inside {ST_TAMPER, ST_GAP, ST_ERROR};
    end
  end
  assign spi_cs_n = cs_n_reg;

  // ==========================================================
  // output buffer and status
  assign push = hv && !hfail && discard_reg == '0; // [R13]
  rnh_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data(rx_sh_reg),
    .out_valid(noise_valid),
    .out_ready(noise_ready),
    .out_data(noise_data)
  );
  assign svc_ready = discard_reg == '0 && st_reg != ST_ERROR;
  assign err_code = err_reg;
  assign reboot_req = reboot_reg;

  // ==========================================================
  // checks
  chk_read_after_ready: assert property ( // [R4]
    st_reg == ST_READ_CMD && $past(st_reg) != ST_READ_CMD |->
    $past(st_reg) == ST_POLL_RSP && $past(rx_sh_reg[STAT_RDY_BIT]))
    else $error("read issued without ready status");
  chk_frame_sixteen: assert property ( // [R5]
    st_reg == ST_GAP && $past(st_reg) == ST_READ_DATA |->
    $past(idx_reg) == 5'(FRAME_BYTES - 1))
    else $error("frame ended at wrong byte count");
  chk_valid_frame_only: assert property ( // [R6]
    st_reg == ST_READ_DATA && $past(st_reg) == ST_READ_HDR |->
    $past(rx_sh_reg) == FRAME_HDR)
    else $error("data phase entered without valid header");
  chk_retry_bound: assert property ( // [R7]
    done_reg && st_reg == ST_READ_HDR && rx_sh_reg != FRAME_HDR &&
    retry_reg == RW'(RETRIES) && !restart |=>
    st_reg == ST_ERROR && err_reg == ERR_READ && reboot_req)
    else $error("retries exhausted without read error");
  chk_init_first: assert property ( // [R10]
    st_reg == ST_GAP && $past(st_reg) == ST_INIT |->
    $past(idx_reg) == 5'(INIT_LEN - 1) && $past(done_reg))
    else $error("init sequence cut short");
  chk_discard_hold: assert property ( // [R13]
    st_reg == ST_GAP && $past(st_reg) == ST_READ_DATA &&
    $past(discard_reg) != '0 |-> discard_reg == $past(discard_reg) - 1'b1)
    else $error("start-up frame not counted off");
  chk_push_room: assert property ( // [R3]
    push |-> fifo_in_ready)
    else $error("byte pushed into a full buffer");
  chk_run_cutoff: assert property ( // [R14]
    hv && run_next == RUN_CUT && !restart |=>
    st_reg == ST_ERROR && err_reg == ERR_RUN)
    else $error("run cutoff not acted on");
  chk_window_cutoff: assert property ( // [R15]
    hv && wcnt_next == WIN_CUT && !run_hit && !restart |=>
    st_reg == ST_ERROR && err_reg == ERR_WINDOW ##1 st_reg == ST_ERROR)
    else $error("window cutoff not acted on");
  chk_error_halts: assert property ( // [R16]
    st_reg == ST_ERROR && !restart |=> st_reg == ST_ERROR &&
    spi_cs_n && !busy_reg)
    else $error("activity after error");
  chk_tamper_fail: assert property ( // [R19]
    st_reg == ST_TAMPER && !tamper_ok && !restart &&
    wait_reg == TW'(TAMPER_WAIT_CYC - 1) |=> err_reg == ERR_TAMPER)
    else $error("tamper timeout not reported");
  chk_run_reset: assert property ( // [R20]
    hv && have_prev_reg && rx_sh_reg != prev_reg && !restart |=>
    run_reg == 5'h01)
    else $error("run count not restarted");
  chk_window_ref: assert property ( // [R21]
    hv && widx_reg == '0 && !restart |=>
    wref_reg == $past(rx_sh_reg) && wcnt_reg == 9'h001)
    else $error("window reference not taken");

  cov_frame_pushed: cover property (push ##[1:300] push);
  cov_retry: cover property (st_reg == ST_READ_HDR ##1 st_reg == ST_GAP);
  cov_run_fail: cover property (err_reg == ERR_RUN);
  cov_stall: cover property (st_reg == ST_READ_DATA && !fifo_in_ready);
endmodule : rnh_ctrl
`default_nettype wire

// [rtl/rnh_fifo.sv]
/*
 * small synchronous fifo with valid/ready on both sides.
 * assumes one clock and an active-low asynchronous reset.
 */
`timescale 1ns/1ps
`default_nettype none
module rnh_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  // ==========================================================
  // parameter check: pointers wrap naturally only at powers of two
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("rnh_fifo depth must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wptr_reg;
  logic [AW:0] rptr_reg;
  logic do_push;
  logic do_pop;

  // full when pointers differ only in the wrap bit
  assign in_ready = (wptr_reg ^ rptr_reg) != {1'b1, {AW{1'b0}}};
  assign out_valid = wptr_reg != rptr_reg;
  assign out_data = mem[rptr_reg[AW-1:0]];
  assign do_push = in_valid && in_ready;
  assign do_pop = out_valid && out_ready;

  // storage has no reset; only pointers need a defined value
  always_ff @(posedge clk_sys) begin
    if (do_push) begin
      mem[wptr_reg[AW-1:0]] <= in_data;
    end
  end

  // pointer update
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
    end else begin
      if (do_push) begin
        wptr_reg <= wptr_reg + 1'b1;
      end
      if (do_pop) begin
        rptr_reg <= rptr_reg + 1'b1;
      end
    end
  end

  // occupancy bound: catches a broken full flag that lets a push overwrite
  chk_no_overfill: assert property ( // [R3]
    @(posedge clk_sys) disable iff (!resetn)
    (wptr_reg - rptr_reg) <= (AW + 1)'(DEPTH))
    else $error("fifo holds more than its depth");
endmodule : rnh_fifo
`default_nettype wire

// [rtl/rnh_pkg.sv]
/*
 * constants shared by the noise readout controller, its chip model and bench.
 * assumes a 125 MHz system clock and a spi-strapped noise chip.
 */
package rnh_pkg;
  // ==========================================================
  // clock and link timing
  localparam int CLK_NS = 8;
  localparam int SPI_HALF_NS = 40;
  localparam int SPI_DIV_CYC = (SPI_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam int TAMPER_WAIT_US = 10;
  localparam int TAMPER_WAIT_CYC = TAMPER_WAIT_US * 1000 / CLK_NS;

  // ==========================================================
  // command bytes and status fields (values arbitrary)
  localparam logic [7:0] CMD_STATUS = 8'h05;
  localparam logic [7:0] CMD_READ = 8'h0b;
  localparam logic [7:0] CMD_DUMMY = 8'h00;
  localparam logic [7:0] FRAME_HDR = 8'ha5;
  localparam int STAT_RDY_BIT = 0;
  localparam int STAT_FAIL_BIT = 1;
  localparam int INIT_LEN = 4;
  localparam logic [7:0] INIT_SEQ [INIT_LEN] = '{8'h01, 8'h20, 8'h31, 8'h7e};

  // ==========================================================
  // frame and health-check figures
  localparam int FRAME_BYTES = 16;
  localparam int DISCARD_BYTES = 4000;
  localparam int DISCARD_FRAMES = DISCARD_BYTES / FRAME_BYTES;
  localparam int MAX_RETRY = 3;
  localparam logic [4:0] RUN_CUT = 5'h15;
  localparam int WIN_LEN = 512;
  localparam logic [8:0] WIN_CUT = 9'hf8;
  localparam int FIFO_DEPTH = 8;

  // ==========================================================
  // error codes
  typedef enum logic [2:0] {
    ERR_NONE = 3'h0,
    ERR_TAMPER = 3'h1,
    ERR_READ = 3'h2,
    ERR_DEVICE = 3'h3,
    ERR_RUN = 3'h4,
    ERR_WINDOW = 3'h5
  } rnh_err_t;
endpackage : rnh_pkg

// [verif/rnh_noise_chip.sv]
/*
 * behavioural raw noise chip on spi mode 0, msb first.
 * assumes the bench fills src_q with packed noise bytes.
 */
`timescale 1ns/1ps
`default_nettype none
module rnh_noise_chip import rnh_pkg::*; (
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  input wire logic rdy_in,
  input wire logic fail_in
);
  // ==========================================================
  // state; strap fixed to the serial peripheral port
  logic [7:0] src_q [$]; // samples already packed
  int bad_left = 0;
  int viol = 0;
  int phase = 0;
  int idx = 0;
  int init_idx = 0;
  int bitc = 0;
  bit init_ok = 1'b0;
  bit shown = 1'b0;
  bit bad_frame = 1'b0;
  logic [7:0] rx = 8'h00;
  logic [7:0] tx = 8'h5a;

  initial spi_miso = 1'b0;

  // reply picked at each byte boundary from the byte received
  function automatic logic [7:0] next_reply(input logic [7:0] b);
    logic [7:0] r;
    r = ~b;
    if (phase == 0 && b === CMD_STATUS) begin
      phase = 1;
      r = 8'h00;
      // fail_in means both emitters lost or calibration gave up
      r[STAT_FAIL_BIT] = fail_in;
      r[STAT_RDY_BIT] = rdy_in && init_ok && src_q.size() >= FRAME_BYTES;
      shown = r[STAT_RDY_BIT];
    end else if (phase == 0 && b === CMD_READ) begin
      if (!shown) viol++;
      shown = 1'b0;
      phase = 2;
      idx = 0;
      bad_frame = (bad_left > 0);
      if (bad_frame) bad_left--;
      r = bad_frame ? ~FRAME_HDR : FRAME_HDR;
    end else if (phase == 0) begin
      // data is only offered once the start-up bytes arrived in order
      if (init_idx < INIT_LEN && b === INIT_SEQ[init_idx]) init_idx++;
      else init_idx = 0;
      if (init_idx == INIT_LEN) init_ok = 1'b1;
    end else if (phase == 1 || idx >= FRAME_BYTES) begin
      phase = 0;
    end else begin
      if (!bad_frame) r = src_q.pop_front(); // raw, unconditioned
      idx++;
    end
    return r;
  endfunction : next_reply

  // every select starts a fresh byte
  always @(negedge spi_cs_n) begin
    bitc = 0;
    init_idx = 0;
    phase = 0;
    spi_miso = tx[7];
  end

  // released line shows the inverse of its last level
  always @(posedge spi_cs_n) spi_miso = ~spi_miso;

  // sample on the rising edge, shift out after the falling edge
  always @(posedge spi_sclk) begin
    if (!spi_cs_n) begin
      rx = {rx[6:0], spi_mosi};
      bitc++;
      if (bitc == 8) begin
        bitc = 0;
        tx = next_reply(rx);
      end else begin
        tx = {tx[6:0], 1'b0};
      end
    end
  end

  // next bit placed while the clock is low
  always @(negedge spi_sclk) begin
    if (!spi_cs_n) spi_miso = tx[7];
  end
endmodule : rnh_noise_chip
`default_nettype wire

// [verif/tb.sv]
/*
 * self-checking bench for rnh_ctrl against a reference of the checks.
 * assumes rnh_noise_chip as the far side and a 125 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none
module tb import rnh_pkg::*; ;
  // ==========================================================
  // signals and reference state
  localparam int DISC = 2;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic restart = 1'b0;
  logic tamper_ok = 1'b0;
  logic noise_ready = 1'b0;
  logic rdy_in = 1'b0;
  logic fail_in = 1'b0;
  logic stall = 1'b0;
  logic spi_sclk, spi_cs_n, spi_mosi, spi_miso;
  logic noise_valid, svc_ready, reboot_req, sclk_d;
  logic [7:0] noise_data;
  logic [2:0] err_code;
  logic [7:0] rb_cnt = 8'h00;
  logic [7:0] sclk_rises = 8'h00;
  logic [7:0] exp_q [$];
  logic [7:0] last_b, ref_b;
  int bad_count = 0;
  int samples_checked = 0;
  int run_n, win_pos, win_n, frames;
  rnh_err_t exp_err;

  initial begin
    forever #4 clk_sys = ~clk_sys;
  end

  rnh_ctrl #(.SPI_DIV(2), .DISCARD(DISC), .RETRIES(MAX_RETRY)) uut (
    .clk_sys(clk_sys), .resetn(resetn), .restart(restart),
    .tamper_ok(tamper_ok), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi), .spi_miso(spi_miso), .noise_data(noise_data),
    .noise_valid(noise_valid), .noise_ready(noise_ready),
    .svc_ready(svc_ready), .err_code(err_code), .reboot_req(reboot_req));

  rnh_noise_chip dev (.spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi), .spi_miso(spi_miso), .rdy_in(rdy_in),
    .fail_in(fail_in));

  // ==========================================================
  // reporting
  task automatic complete_run();
    $display("checks %0d errors %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run

  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t byte %h expected %h", $time, got, exp);
    end
  endtask : cmp_byte

  task automatic cmp_code(input logic [2:0] got, input logic [2:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t code %h expected %h", $time, got, exp);
    end
  endtask : cmp_code

  task automatic cmp_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t flag %b expected %b", $time, got, exp);
    end
  endtask : cmp_bit

  // random back-pressure and readiness, output monitor
  always @(posedge clk_sys) begin
    noise_ready <= !stall && ($urandom % 4 != 0);
    rdy_in <= ($urandom % 3 != 0);
    sclk_d <= spi_sclk;
    if (spi_sclk === 1'b1 && sclk_d === 1'b0) begin
      sclk_rises <= sclk_rises + 8'h01;
    end
    // pulses counted per run; a restart starts the count over
    if (restart === 1'b1) rb_cnt <= 8'h00;
    else if (reboot_req === 1'b1) rb_cnt <= rb_cnt + 8'h01;
    if (noise_valid === 1'b1 && noise_ready === 1'b1) begin
      if (exp_q.size() == 0) begin
        bad_count++;
        $display("ERROR %0t unexpected byte %h", $time, noise_data);
      end else begin
        cmp_byte(noise_data, exp_q.pop_front());
      end
    end
  end

  // ==========================================================
  // reference checks over every validated byte since restart
  task automatic ref_byte(input logic [7:0] b);
    if (exp_err != ERR_NONE) return;
    run_n = (run_n > 0 && b === last_b) ? run_n + 1 : 1;
    last_b = b;
    if (win_pos == 0) ref_b = b;
    win_n = (win_pos == 0) ? 1 : win_n + int'(b === ref_b);
    win_pos = (win_pos + 1) % WIN_LEN;
    if (run_n >= int'(RUN_CUT)) exp_err = ERR_RUN;
    else if (win_n >= int'(WIN_CUT)) exp_err = ERR_WINDOW;
    else if (frames >= DISC) exp_q.push_back(b);
  endtask : ref_byte

  task automatic feed(input logic [7:0] q [$]);
    foreach (q[i]) begin
      dev.src_q.push_back(q[i]);
      ref_byte(q[i]);
      if (i % FRAME_BYTES == FRAME_BYTES - 1) frames++;
    end
  endtask : feed

  task automatic feed_rand(input int n);
    logic [7:0] q [$];
    repeat (n * FRAME_BYTES) q.push_back(8'($urandom));
    feed(q);
  endtask : feed_rand

  // bounded wait for the traffic to drain or an error to show
  task automatic settle();
    int n;
    n = 0;
    while (n < 40000 && err_code === ERR_NONE && (exp_err != ERR_NONE ||
           dev.src_q.size() != 0 || exp_q.size() != 0)) begin
      @(posedge clk_sys);
      n++;
    end
    if (n == 40000) begin
      bad_count++;
      $display("ERROR %0t wait expired", $time);
      complete_run();
    end
    // the last byte of a frame is still on the wire when the queue empties
    repeat (100) @(posedge clk_sys);
    cmp_code(err_code, exp_err);
    if (exp_err != ERR_NONE) begin
      cmp_bit(svc_ready, 1'b0);
      cmp_byte(rb_cnt, 8'h01);
    end
  endtask : settle

  task automatic do_restart();
    int n;
    n = 0;
    while (n < 300 && noise_valid === 1'b1) begin
      @(posedge clk_sys);
      n++;
    end
    if (n == 300) begin
      bad_count++;
      $display("ERROR %0t drain wait expired", $time);
      complete_run();
    end
    cmp_byte(8'(exp_q.size()), 8'h00);
    restart <= 1'b1;
    tamper_ok <= 1'b1;
    fail_in <= 1'b0;
    @(posedge clk_sys);
    restart <= 1'b0;
    dev.src_q.delete();
    dev.bad_left = 0;
    exp_q.delete();
    run_n = 0;
    win_pos = 0;
    frames = 0;
    exp_err = ERR_NONE;
    repeat (2) @(posedge clk_sys);
    cmp_bit(svc_ready, 1'b0);
  endtask : do_restart

  // ==========================================================
  // main sequence
  initial begin
    logic [7:0] q [$];
    logic [7:0] v;
    logic [7:0] s0;
    void'($urandom(80));
    run_n = 0;
    win_pos = 0;
    frames = 0;
    exp_err = ERR_TAMPER;
    repeat (6) @(posedge clk_sys);
    cmp_bit(spi_cs_n, 1'b1);
    cmp_bit(noise_valid, 1'b0);
    resetn <= 1'b1;
    settle();
    cmp_bit(spi_cs_n, 1'b1);
    do_restart();
    feed_rand(DISC);
    settle();
    cmp_bit(svc_ready, 1'b1);
    feed_rand(6);
    settle();
    stall = 1'b1;
    feed_rand(4);
    repeat (1500) @(posedge clk_sys);
    s0 = sclk_rises;
    repeat (300) @(posedge clk_sys);
    cmp_byte(sclk_rises - s0, 8'h00);
    cmp_bit(noise_valid, 1'b1);
    stall = 1'b0;
    settle();
    dev.bad_left = MAX_RETRY;
    feed_rand(2);
    settle();
    dev.bad_left = MAX_RETRY + 1;
    repeat (FRAME_BYTES) dev.src_q.push_back(8'h3c);
    exp_err = ERR_READ;
    settle();
    do_restart();
    feed_rand(DISC);
    v = dev.src_q[$] + 8'h01;
    repeat (20) q.push_back(v);
    q.push_back(~v);
    repeat (27) q.push_back(v);
    feed(q);
    settle();
    do_restart();
    v = 8'($urandom);
    q = {};
    for (int i = 0; i < 31 * FRAME_BYTES; i++) begin
      q.push_back(i % 2 == 0 ? v : v ^ (8'($urandom % 255) + 8'h01));
    end
    feed(q);
    settle();
    do_restart();
    fail_in <= 1'b1;
    exp_err = ERR_DEVICE;
    settle();
    cmp_byte(8'(dev.viol), 8'h00);
    complete_run();
  end
endmodule : tb
`default_nettype wire
